/* rtl/uhmd_pkg.sv */
/*
 * Package for the half-duplex / multidrop line-control block: mode codes,
 * field positions, widths and reset values.
 * Assumes a single 40 MHz clock domain and a bit-rate tick from the baud generator.
 */
package uhmd_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 25;
	localparam int unsigned CHAR_W         = 8;
	localparam int unsigned DELAY_W        = 4;
	localparam int unsigned MODE_W         = 3;
	// line-control mode register fields
	localparam int unsigned MODE_SEL_LSB   = 0;
	localparam int unsigned HALF_DUPLEX_BIT = 3;
	// pin-function register fields
	localparam int unsigned XCVR_POL_BIT   = 3;
	localparam logic [MODE_W-1:0] MODE_SWFLOW    = 3'h2;
	localparam logic [MODE_W-1:0] MODE_ADDR_TX   = 3'h3;
	localparam logic [MODE_W-1:0] MODE_ADDR_GATE = 3'h4;
	localparam logic [DELAY_W-1:0] DELAY_RESET   = 4'h0;
	localparam logic [DELAY_W-1:0] DELAY_MAX     = 4'hF;

	typedef enum logic [1:0] {
		UHMD_DIR_IDLE  = 2'b00,
		UHMD_DIR_SEND  = 2'b01,
		UHMD_DIR_HOLD  = 2'b10
	} uhmd_dir_e;
endpackage

/* rtl/uhmd_addr_filter.sv */
/*
 * Receive-side multidrop address filter and in-band pause/resume detector.
 * Assumes one received character per rx_valid_i pulse, ninth bit alongside.
 */
`timescale 1ns/100ps
module uhmd_addr_filter
	import uhmd_pkg::*;
(
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	// configuration
	input  wire logic              addr_mode_i,
	input  wire logic              swflow_mode_i,
	input  wire logic [CHAR_W-1:0] unicast_addr_i,
	input  wire logic [CHAR_W-1:0] multicast_addr_i,
	// received characters
	input  wire logic              rx_valid_i,
	input  wire logic [CHAR_W-1:0] rx_data_i,
	input  wire logic              rx_bit9_i,
	// results
	output logic                   store_valid_o,
	output logic [CHAR_W-1:0]      store_data_o,
	output logic                   addr_matched_o,
	output logic                   tx_paused_o
);
	logic              matched_ff, nxt_matched;
	logic              paused_ff, nxt_paused;
	logic              store_ff, nxt_store;
	logic [CHAR_W-1:0] data_ff, nxt_data;
	logic              is_addr, hit;

	always_comb begin
		is_addr     = rx_bit9_i;
		hit         = (rx_data_i == unicast_addr_i) || (rx_data_i == multicast_addr_i);
		nxt_matched = matched_ff;
		nxt_paused  = paused_ff;
		nxt_store   = 1'b0;
		nxt_data    = data_ff;
		if (!addr_mode_i) begin
			nxt_matched = 1'b0;
		end
		if (!swflow_mode_i) begin
			nxt_paused = 1'b0;
		end
		if (rx_valid_i) begin
			if (addr_mode_i) begin
				if (is_addr) begin
					// address byte itself is never stored
					nxt_matched = hit;
				end else if (matched_ff) begin
					nxt_store = 1'b1;
					nxt_data  = rx_data_i;
				end
			end else begin
				nxt_store = 1'b1;
				nxt_data  = rx_data_i;
				if (swflow_mode_i) begin
					// first char resumes, second pauses
					if (rx_data_i == unicast_addr_i) begin
						nxt_paused = 1'b0;
					end else if (rx_data_i == multicast_addr_i) begin
						nxt_paused = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			matched_ff <= 1'b0;
			paused_ff  <= 1'b0;
			store_ff   <= 1'b0;
			data_ff    <= '0;
		end else begin
			matched_ff <= nxt_matched;
			paused_ff  <= nxt_paused;
			store_ff   <= nxt_store;
			data_ff    <= nxt_data;
		end
	end

	assign store_valid_o  = store_ff;
	assign store_data_o   = data_ff;
	assign addr_matched_o = matched_ff;
	assign tx_paused_o    = paused_ff;
endmodule

/* rtl/uhmd_line_ctrl.sv */
/*
 * Line control of a half-duplex multidrop UART: transceiver direction output
 * with turn-around delay and polarity, transmit gating, receive blanking.
 * Assumes the shifter holds tx_start_req_i until it sees tx_start_ok_o,
 * reports tx_stop_done_i after the final stop bit, and bit_tick_i once per bit.
 */
`timescale 1ns/100ps
module uhmd_line_ctrl
	import uhmd_pkg::*;
(
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               reset_i,
	// configuration
	input  wire logic [3:0]         line_mode_cfg_i,
	input  wire logic [3:0]         pin_func_cfg_i,
	input  wire logic               xcvr_auto_en_i,
	input  wire logic [DELAY_W-1:0] turnaround_delay_cfg_i,
	input  wire logic [CHAR_W-1:0]  unicast_addr_i,
	input  wire logic [CHAR_W-1:0]  multicast_addr_i,
	// bit-rate timing
	input  wire logic               bit_tick_i,
	// transmit shifter side
	input  wire logic               tx_start_req_i,
	input  wire logic               tx_stop_done_i,
	input  wire logic               tx_fifo_empty_i,
	output logic                    tx_start_ok_o,
	// receive shifter side
	input  wire logic               rx_valid_i,
	input  wire logic [CHAR_W-1:0]  rx_data_i,
	input  wire logic               rx_bit9_i,
	output logic                    rx_store_valid_o,
	output logic [CHAR_W-1:0]       rx_store_data_o,
	// pins and status
	output logic                    xcvr_direction_out_o,
	output logic                    rx_blank_o,
	output logic                    addr_matched_o
);
	uhmd_dir_e          state_ff, nxt_state;
	logic [DELAY_W-1:0] cnt_ff, nxt_cnt;
	logic               dir_ff, nxt_dir;
	logic               busy_ff, nxt_busy;
	logic [MODE_W-1:0]  mode;
	logic               addr_mode, swflow_mode, half_duplex;
	logic               gate_ok, paused, matched;
	logic               start_want, last_stop, hold_done, dir_active;
	logic               filt_valid;

	// mode decoders feeding the filter; the transmit gate decodes the mode itself
	function automatic logic uhmd_is_addr_mode(input logic [MODE_W-1:0] m);
		return (m == MODE_ADDR_TX) || (m == MODE_ADDR_GATE);
	endfunction

	function automatic logic uhmd_is_swflow_mode(input logic [MODE_W-1:0] m);
		return m == MODE_SWFLOW;
	endfunction

	// gating only holds off a new start, never a character in flight
	function automatic logic uhmd_tx_allowed(
		input logic [MODE_W-1:0] m,
		input logic              hit,
		input logic              hold_off
	);
		logic allow;
		case (m)
			MODE_ADDR_GATE: begin
				allow = hit;
			end
			MODE_SWFLOW: begin
				allow = !hold_off;
			end
			default: begin
				allow = 1'b1;
			end
		endcase
		return allow;
	endfunction

	// polarity bit set means active high
	function automatic logic uhmd_pin_level(input logic active, input logic pol);
		return active ~^ pol;
	endfunction

	assign mode        = line_mode_cfg_i[MODE_SEL_LSB +: MODE_W];
	assign addr_mode   = uhmd_is_addr_mode(mode);
	assign swflow_mode = uhmd_is_swflow_mode(mode);
	assign half_duplex = line_mode_cfg_i[HALF_DUPLEX_BIT];

	assign gate_ok    = uhmd_tx_allowed(mode, matched, paused);
	assign start_want = tx_start_req_i && gate_ok;
	assign last_stop  = tx_stop_done_i && tx_fifo_empty_i;
	assign hold_done  = bit_tick_i && (cnt_ff == 4'h1);

	// start waits one cycle until direction is already active
	assign tx_start_ok_o = start_want &&
		(!xcvr_auto_en_i || state_ff == UHMD_DIR_SEND);

	// direction state and turn-around count
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			UHMD_DIR_IDLE: begin
				if (xcvr_auto_en_i && start_want) begin
					nxt_state = UHMD_DIR_SEND;
				end
			end
			UHMD_DIR_SEND: begin
				if (last_stop) begin
					if (turnaround_delay_cfg_i == DELAY_RESET) begin
						nxt_state = UHMD_DIR_IDLE;
					end else begin
						nxt_state = UHMD_DIR_HOLD;
						nxt_cnt   = turnaround_delay_cfg_i;
					end
				end
			end
			UHMD_DIR_HOLD: begin
				// new character during the delay keeps the line driven
				if (start_want) begin
					nxt_state = UHMD_DIR_SEND;
				end else if (bit_tick_i) begin
					nxt_cnt = cnt_ff - 4'h1;
					if (hold_done) begin
						nxt_state = UHMD_DIR_IDLE;
					end
				end
			end
			default: begin
				nxt_state = UHMD_DIR_IDLE;
			end
		endcase
		// dropping the enable releases the pin at once
		if (!xcvr_auto_en_i) begin
			nxt_state = UHMD_DIR_IDLE;
			nxt_cnt   = DELAY_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_ff <= UHMD_DIR_IDLE;
			cnt_ff   <= DELAY_RESET;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	// pin level registered so the transceiver never sees a glitch
	always_comb begin
		dir_active = nxt_state != UHMD_DIR_IDLE;
		nxt_dir    = uhmd_pin_level(dir_active, pin_func_cfg_i[XCVR_POL_BIT]);
	end

	// low in reset: with active-low polarity the pin reads active until released
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dir_ff <= 1'b0;
		end else begin
			dir_ff <= nxt_dir;
		end
	end

	// character in flight, from grant to its stop bit
	always_comb begin
		nxt_busy = busy_ff;
		// a grant meeting the old stop pulse wins: the next character is on
		if (tx_start_ok_o) begin
			nxt_busy = 1'b1;
		end else if (tx_stop_done_i) begin
			nxt_busy = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= nxt_busy;
		end
	end

	// blanking while a character is on the line
	assign rx_blank_o = half_duplex && busy_ff;
	assign filt_valid = rx_valid_i && !rx_blank_o;

	// filter sees no character while receive is blanked
	uhmd_addr_filter u_filter (
		.clk_i            (clk_i),
		.reset_i          (reset_i),
		.addr_mode_i      (addr_mode),
		.swflow_mode_i    (swflow_mode),
		.unicast_addr_i   (unicast_addr_i),
		.multicast_addr_i (multicast_addr_i),
		.rx_valid_i       (filt_valid),
		.rx_data_i        (rx_data_i),
		.rx_bit9_i        (rx_bit9_i),
		.store_valid_o    (rx_store_valid_o),
		.store_data_o     (rx_store_data_o),
		.addr_matched_o   (matched),
		.tx_paused_o      (paused)
	);

	assign xcvr_direction_out_o = dir_ff;
	assign addr_matched_o       = matched;
endmodule

/* tb/uhmd_line_ctrl_sva.sv */
/* Port assertions for uhmd_line_ctrl.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module uhmd_line_ctrl_sva
	import uhmd_pkg::*;
(
	input wire logic               clk_i,
	input wire logic               reset_i,
	input wire logic [3:0]         line_mode_cfg_i,
	input wire logic [3:0]         pin_func_cfg_i,
	input wire logic               xcvr_auto_en_i,
	input wire logic [DELAY_W-1:0] turnaround_delay_cfg_i,
	input wire logic [CHAR_W-1:0]  unicast_addr_i,
	input wire logic [CHAR_W-1:0]  multicast_addr_i,
	input wire logic               tx_stop_done_i,
	input wire logic               tx_fifo_empty_i,
	input wire logic               tx_start_req_i,
	input wire logic               tx_start_ok_o,
	input wire logic               rx_valid_i,
	input wire logic [CHAR_W-1:0]  rx_data_i,
	input wire logic               rx_bit9_i,
	input wire logic               rx_store_valid_o,
	input wire logic               xcvr_direction_out_o,
	input wire logic               rx_blank_o,
	input wire logic               addr_matched_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire am  = line_mode_cfg_i[2:0] inside {MODE_ADDR_TX, MODE_ADDR_GATE};
	wire pol = pin_func_cfg_i[XCVR_POL_BIT];
	wire adr = rx_valid_i && rx_bit9_i && !rx_blank_o && am;
	wire hit = rx_data_i == unicast_addr_i || rx_data_i == multicast_addr_i;
	sequence last_stop;
		xcvr_auto_en_i && tx_stop_done_i && tx_fifo_empty_i && !tx_start_req_i;
	endsequence
	start_dir_a: assert property (xcvr_auto_en_i && tx_start_ok_o |-> xcvr_direction_out_o == pol)
		else $error("direction idle at start");
	quick_release_a: assert property (last_stop ##0 turnaround_delay_cfg_i == 4'h0 |=> xcvr_direction_out_o == !pol)
		else $error("direction not released");
	delay_hold_a: assert property (last_stop ##0 turnaround_delay_cfg_i != 4'h0 |=> xcvr_direction_out_o == pol)
		else $error("direction released early");
	addr_drop_a: assert property (adr |=> !rx_store_valid_o)
		else $error("address byte stored");
	addr_hit_a: assert property (adr && hit |=> addr_matched_o)
		else $error("match missed");
	addr_miss_a: assert property (adr && !hit |=> !addr_matched_o)
		else $error("mismatch not seen");
	tx_gate_a: assert property (line_mode_cfg_i[2:0] == MODE_ADDR_GATE && !addr_matched_o |-> !tx_start_ok_o)
		else $error("gated start granted");
	hd_blank_a: assert property (line_mode_cfg_i[HALF_DUPLEX_BIT] && tx_start_req_i && tx_start_ok_o |=> rx_blank_o)
		else $error("receive not blanked");
endmodule
bind uhmd_line_ctrl uhmd_line_ctrl_sva chk_u (.*);

/* tb/uhmd_shift_model.sv */
/* Transmit shifter and bit timing facing the line control.
   Assumes a 4-cycle bit time and 10-bit characters. */
`timescale 1ns/100ps
module uhmd_shift_model (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// queue and grant
	input  wire logic queued_i,
	input  wire logic tx_start_ok_i,
	// timing to the block
	output logic      bit_tick_o,
	output logic      tx_start_req_o,
	output logic      tx_stop_done_o
);
	logic [1:0] div_ff;
	logic [3:0] bits_ff;
	logic       busy_ff;
	assign bit_tick_o = div_ff == 2'h3;
	// held until granted, never inside a character
	assign tx_start_req_o = queued_i && !busy_ff;
	always_ff @(posedge clk_i) begin
		div_ff <= reset_i ? 2'h0 : div_ff + 2'h1;
		tx_stop_done_o <= !reset_i && busy_ff && bit_tick_o && bits_ff == 4'h9;
		busy_ff <= !reset_i && (tx_start_req_o && tx_start_ok_i || busy_ff && !(bit_tick_o && bits_ff == 4'h9));
		bits_ff <= tx_start_ok_i ? 4'h0 : bits_ff + {3'h0, bit_tick_o};
	end
endmodule

/* tb/uhmd_line_ctrl_tb.sv */
/* Self-checking bench for uhmd_line_ctrl.
   Assumes the shifter model supplies bit ticks and character ends. */
`timescale 1ns/100ps
module uhmd_line_ctrl_tb;
	logic       clk_i = 0, reset_i = 1, queued = 0, rxv = 0, rx9 = 0, tick, req, stop, ok;
	logic       stv, dir, blank, matched;
	logic       auto_en = 1;
	logic [3:0] mode = 4'h3, pin = 4'h8, dly = 4'h0;
	logic [7:0] uni = 8'h21, mul = 8'h7E, rxd = 8'h00, sdat;
	int         n_fail = 0, comparisons = 0, i;
	always #12.5 clk_i = ~clk_i;
	uhmd_shift_model mdl_u (.clk_i, .reset_i, .queued_i(queued), .tx_start_ok_i(ok),
		.bit_tick_o(tick), .tx_start_req_o(req), .tx_stop_done_o(stop));
	uhmd_line_ctrl dut_u (.clk_i, .reset_i, .line_mode_cfg_i(mode), .pin_func_cfg_i(pin),
		.xcvr_auto_en_i(auto_en), .turnaround_delay_cfg_i(dly), .unicast_addr_i(uni),
		.multicast_addr_i(mul), .bit_tick_i(tick), .tx_start_req_i(req), .tx_stop_done_i(stop),
		.tx_fifo_empty_i(!queued), .tx_start_ok_o(ok), .rx_valid_i(rxv), .rx_data_i(rxd),
		.rx_bit9_i(rx9), .rx_store_valid_o(stv), .rx_store_data_o(sdat),
		.xcvr_direction_out_o(dir), .rx_blank_o(blank), .addr_matched_o(matched));
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		if (n_fail == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic step;
		@(posedge clk_i);
		#1;
	endtask
	task automatic tmo(input logic v);
		if (v !== 1'b1) begin
			n_fail++;
			close_out;
		end
	endtask
	task automatic rx(input logic [7:0] d, input logic b9, exp);
		rxd = d;
		rx9 = b9;
		rxv = 1;
		step;
		rxv = 0;
		chk("store", stv, exp);
		if (exp)
			chk("data", sdat, d);
		// one idle edge so back-to-back calls always drop the strobe between characters
		step;
	endtask
	// one character; n is the expected count of extra bit times
	task automatic send(input int n);
		int t;
		queued = 1;
		for (i = 0; i < 99 && !ok; i++) step;
		tmo(ok);
		chk("dir_on", dir, pin[3]);
		step;
		queued = 0;
		chk("no_blank", blank, mode[3]);
		for (i = 0; i < 99 && !stop; i++) step;
		tmo(stop);
		for (t = 0; i < 199 && dir === pin[3]; i++) begin
			t += tick;
			step;
		end
		chk("ticks", 8'(t), 8'(n));
		chk("dir_off", dir, !pin[3]);
	endtask
	initial begin
		repeat (5) step;
		reset_i = 0;
		step;
		chk("idle", dir, !pin[3]);
		send(0);
		dly = 4'h3;
		send(3);
		pin = 4'h0;
		dly = 4'h0;
		send(0);
		rx(uni, 1, 0);
		chk("matched", matched, 1);
		rx(8'h5A, 0, 1);
		mode = 4'hB;
		queued = 1;
		for (i = 0; i < 99 && !ok; i++) step;
		tmo(ok);
		step;
		queued = 0;
		chk("blank", blank, 1);
		rx(8'h66, 0, 0);
		for (i = 0; i < 99 && !stop; i++) step;
		tmo(stop);
		step;
		chk("unblank", blank, 0);
		rx(8'h67, 0, 1);
		rx(8'h99, 1, 0);
		chk("unmatched", matched, 0);
		rx(8'h11, 0, 0);
		rx(mul, 1, 0);
		rx(8'h12, 0, 1);
		mode = 4'h4;
		rx(8'h98, 1, 0);
		queued = 1;
		repeat (12) step;
		chk("gated", ok, 0);
		rx(uni, 1, 0);
		send(0);
		mode = 4'h0;
		rx(8'h98, 1, 1);
		chk("no_match", matched, 0);
		mode = 4'h2;
		rx(mul, 0, 1);
		queued = 1;
		repeat (12) step;
		chk("paused", ok, 0);
		rx(uni, 0, 1);
		send(0);
		// direction control off: grant at once, pin never driven
		auto_en = 0;
		queued = 1;
		#1 chk("ok_now", ok, 1);
		step;
		queued = 0;
		chk("dir_manual", dir, !pin[3]);
		for (i = 0; i < 99 && !stop; i++) step;
		tmo(stop);
		chk("dir_still", dir, !pin[3]);
		close_out;
	end
endmodule
